// *** rtl/rtsu_top.sv ***
// rtc divider chain, rate selector, update cycle and wishbone registers
// What this block does
// [R1] one 4-bit rate field sets both periodic flag rate and square-wave frequency
// [R2] square wave gated by its enable, periodic irq gated by its enable
// [R3] oscillator field 010 runs oscillator and advances the divider chain
// [R4] oscillator field 11x runs oscillator but holds divider chain in reset
// [R5] any other oscillator field value keeps the oscillator stopped
// [R6] after reset the oscillator is stopped until software enables it
// [R7] rate codes decode to taps from 8.192 kHz down to 2 Hz, 0 none
// [R8] thirteen chain taps feed one shared selector for both outputs
// [R9] an update cycle runs every second whatever the set bit
// [R10] set freezes the user time copy while internal time keeps counting
// [R11] update compares alarm bytes to time, don't-care codes always match
// [R12] update-ended flag rises after each update, over 999 ms before next change
// [R13] update-in-progress pulses each second; transfer comes 244 us after its rise
// [R14] while update-in-progress is low, user time holds for at least 244 us
// [R15] host should finish time reads within 244 us of seeing it low
// [R16] update-in-progress high interval sits between periodic flag settings; here it rises as the selected tap falls, a cycle before the flag sets
// [R17] host reads timed by periodic irq finish within half interval plus update
// [R18] host clears the irq flags by reading status before leaving handler
// [R19] square-wave pin low while its enable is 0; reset clears that enable
// [R20] periodic flag set on each falling edge of the selected tap; status read or reset clears
// [R21] irq pin and summary flag asserted when any flag meets its enable
// [R22] divider chain runs from a 32.768 kHz time base
// [R23] update-in-progress high time is a parameter of at least 244 us
`timescale 1ns/1ps
module rtsu_top #(
  parameter int unsigned TB_RATE = rtsu_pkg::TB_HZ,
  parameter int unsigned UPD_CYC = rtsu_pkg::UPD_CYCLE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire rtsu_pkg::rtsu_wb_req_t i_wb_req,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output logic o_square_wave_out,
  output logic o_irq_out,
  output logic o_irq_oe_n
);
  import rtsu_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] acc_r;
  logic [CHAIN_W-1:0] chain_r;
  logic [3:0] rate_r;
  logic [2:0] osc_r;
  logic [7:0] b_r;
  logic per_flag_r, alm_flag_r, end_flag_r, tap_prev_r;
  rtsu_upd_t state_r, st_nxt;
  logic [15:0] ucnt_r, cnt_nxt;
  rtsu_time_t time_int_r, time_usr_r, alarm_r;
  logic xfer, upd_end;

  // ------------------------------------------------------------
  // time base and divider chain
  // ------------------------------------------------------------
  // fractional accumulator turns 10 MHz into a 32.768 kHz enable
  wire [31:0] acc_sum = acc_r + TB_RATE; // R22
  wire tb_tick = acc_sum >= CLK_HZ;
  wire [31:0] acc_nxt = tb_tick ? acc_sum - CLK_HZ : acc_sum;
  wire osc_run = osc_r == OSC_RUN; // R3
  wire osc_hold = osc_r[2:1] == OSC_HOLD; // R4
  wire chain_adv = osc_run & tb_tick; // R5
  wire sec_tick = chain_adv & (&chain_r);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      acc_r <= 32'h0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      chain_r <= '0;
    end else if (osc_hold) begin
      chain_r <= '0; // R4
    end else if (chain_adv) begin
      chain_r <= chain_r + 1'b1; // R3
    end
  end

  // ------------------------------------------------------------
  // rate selector, shared by square wave and periodic flag
  // ------------------------------------------------------------
  wire [3:0] tap_idx = (rate_r == RATE_256) ? TAP_256 :
                       (rate_r == RATE_128) ? TAP_128 : rate_r - TAP_OFS; // R7
  wire tap = (rate_r != RATE_NONE) & chain_r[tap_idx]; // R1 R8
  wire tap_fall = tap_prev_r & ~tap; // R20

  // ------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------
  wire wb_hit = i_wb_req.cyc & i_wb_req.stb & ~o_wb_ack;
  wire wr = wb_hit & i_wb_req.we;
  wire rd = wb_hit & ~i_wb_req.we;
  wire at_time = i_wb_req.adr == ADR_TIME;
  wire at_alarm = i_wb_req.adr == ADR_ALARM;
  wire at_a = i_wb_req.adr == ADR_CTRLA;
  wire at_b = i_wb_req.adr == ADR_CTRLB;
  wire at_c = i_wb_req.adr == ADR_STAT;
  wire wr_a = wr & at_a & i_wb_req.sel[0];
  wire wr_b = wr & at_b & i_wb_req.sel[0];
  wire wr_t = wr & at_time & b_r[B_SET];
  wire rd_c = rd & at_c;
  wire updating = state_r != UPD_IDLE;
  wire [7:0] b_nxt = wr_b ? (i_wb_req.dat[7:0] & B_MASK) : b_r;

  // ------------------------------------------------------------
  // flags: a set in the clearing cycle wins over the read clear
  // ------------------------------------------------------------
  rtsu_time_t t_next;
  wire alarm_hit;
  wire per_flag_nxt = tap_fall | (per_flag_r & ~rd_c); // R20
  wire alm_flag_nxt = alarm_hit | (alm_flag_r & ~rd_c);
  wire end_flag_nxt = upd_end | (end_flag_r & ~rd_c); // R12
  wire irq_nxt = (per_flag_nxt & b_nxt[B_PERIODIC_EN]) | (alm_flag_nxt & b_nxt[B_AIE]) |
                 (end_flag_nxt & b_nxt[B_UIE]); // R2 R21
  wire irq_summary = (per_flag_r & b_r[B_PERIODIC_EN]) | (alm_flag_r & b_r[B_AIE]) |
                     (end_flag_r & b_r[B_UIE]);
  wire [7:0] reg_a = {updating, osc_r, rate_r};
  wire [7:0] reg_c = {irq_summary, per_flag_r, alm_flag_r, end_flag_r, 4'h0}; // R21
  wire [31:0] rd_data = at_time ? {8'h00, time_usr_r} :
                        at_alarm ? {8'h00, alarm_r} :
                        at_a ? {24'h0, reg_a} :
                        at_b ? {24'h0, b_r} :
                        at_c ? {24'h0, reg_c} : 32'h0;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_hit;
      o_wb_dat <= rd ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rate_r <= RATE_RESET;
      osc_r <= OSC_RESET; // R6
      b_r <= B_RESET; // R19
    end else begin
      b_r <= b_nxt;
      if (wr_a) begin
        rate_r <= i_wb_req.dat[3:0]; // R1
        osc_r <= i_wb_req.dat[6:4];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      per_flag_r <= 1'b0;
      alm_flag_r <= 1'b0;
      end_flag_r <= 1'b0;
      tap_prev_r <= 1'b0;
      o_square_wave_out <= 1'b0;
      o_irq_out <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else begin
      per_flag_r <= per_flag_nxt;
      alm_flag_r <= alm_flag_nxt;
      end_flag_r <= end_flag_nxt;
      tap_prev_r <= tap;
      o_square_wave_out <= b_nxt[B_SQUARE_EN] & tap; // R2 R19
      o_irq_out <= 1'b0;
      o_irq_oe_n <= ~irq_nxt; // R21
    end
  end

  // ------------------------------------------------------------
  // update cycle: busy flag high for UPD_CYC, transfer after XFER_CYC
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = state_r;
    cnt_nxt = ucnt_r + 16'h0001;
    xfer = 1'b0;
    upd_end = 1'b0;
    unique case (state_r)
      UPD_IDLE: begin
        cnt_nxt = 16'h0000;
        if (sec_tick) begin
          st_nxt = UPD_PRE; // R9 R16
        end
      end
      UPD_PRE: begin
        if (ucnt_r == 16'(XFER_CYC - 1)) begin
          xfer = 1'b1; // R13 R14
          st_nxt = UPD_POST;
        end
      end
      UPD_POST: begin
        if (ucnt_r == 16'(UPD_CYC - 2)) begin
          st_nxt = UPD_END; // R23
        end
      end
      UPD_END: begin
        upd_end = 1'b1; // R12
        st_nxt = UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= UPD_IDLE;
      ucnt_r <= 16'h0000;
    end else begin
      state_r <= st_nxt;
      ucnt_r <= cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // time copies and alarm compare
  // ------------------------------------------------------------
  function automatic rtsu_time_t t_inc(input rtsu_time_t t);
    rtsu_time_t r;
    r = t;
    if (t.sec != SEC_MAX) begin
      r.sec = t.sec + 8'h01;
    end else begin
      r.sec = 8'h00;
      if (t.min != MIN_MAX) begin
        r.min = t.min + 8'h01;
      end else begin
        r.min = 8'h00;
        r.hour = (t.hour == HOUR_MAX) ? 8'h00 : t.hour + 8'h01;
      end
    end
    return r;
  endfunction

  function automatic logic b_ok(input logic [7:0] a, input logic [7:0] t);
    return (a[7:6] == DONT_CARE) || (a == t);
  endfunction

  function automatic rtsu_time_t merge(input rtsu_time_t old, input logic [31:0] d,
                                       input logic [3:0] s);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return rtsu_time_t'(r);
  endfunction

  assign t_next = t_inc(time_int_r);
  assign alarm_hit = xfer & b_ok(alarm_r.sec, t_next.sec) &
                     b_ok(alarm_r.min, t_next.min) & b_ok(alarm_r.hour, t_next.hour); // R11

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      time_int_r <= '0;
      time_usr_r <= '0;
      alarm_r <= '0;
    end else begin
      if (wr & at_alarm) begin
        alarm_r <= merge(alarm_r, i_wb_req.dat, i_wb_req.sel);
      end
      if (wr_t) begin
        time_int_r <= merge(time_int_r, i_wb_req.dat, i_wb_req.sel);
        time_usr_r <= merge(time_int_r, i_wb_req.dat, i_wb_req.sel);
      end else if (xfer) begin
        time_int_r <= t_next; // R10
        if (!b_r[B_SET]) begin
          time_usr_r <= t_next; // R10
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic updating_prev_r;
  logic [15:0] since_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      updating_prev_r <= 1'b0;
      since_r <= 16'hFFFF;
    end else begin
      updating_prev_r <= updating;
      if (updating & ~updating_prev_r) begin
        since_r <= 16'h0001;
      end else if (since_r != 16'hFFFF) begin
        since_r <= since_r + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_square_gated_low: assert property (!b_nxt[B_SQUARE_EN] |=> !o_square_wave_out) // R19
    else $error("square wave high while disabled");
  a_osc_stopped: assert property (!osc_run && !osc_hold |=> $stable(chain_r)) // R5
    else $error("chain moved with oscillator stopped");
  a_chain_held: assert property (osc_hold |=> chain_r == '0) // R4
    else $error("chain not held in reset");
  a_chain_runs: assert property (chain_adv |=> chain_r == $past(chain_r) + 1'b1) // R3
    else $error("chain did not advance");
  a_per_on_edge: assert property (tap_fall |=> per_flag_r) // R20
    else $error("periodic flag missed a tap edge");
  a_irq_summary: assert property (o_irq_oe_n == !reg_c[C_SUMMARY]) // R21
    else $error("irq pin and summary flag disagree");
  a_sec_update: assert property (sec_tick && state_r == UPD_IDLE |=> updating) // R9
    else $error("no update cycle at second tick");
  a_xfer_timing: assert property ($changed(time_usr_r) && !$past(wr_t) |->
                                  updating && since_r == 16'(XFER_CYC)) // R13
    else $error("user time changed outside transfer slot");
  a_set_freezes: assert property (b_r[B_SET] && !wr_t |=> $stable(time_usr_r)) // R10
    else $error("user copy moved while set");
  a_end_after_upd: assert property ($fell(updating) |-> end_flag_r) // R12
    else $error("update-ended flag not set");
  a_alarm_match: assert property (alarm_hit |=> alm_flag_r) // R11
    else $error("alarm match not flagged");
  a_busy_width: assert property ($fell(updating) |-> since_r == 16'(UPD_CYC)) // R23
    else $error("update busy high time wrong");

  c_square_toggle: cover property (b_r[B_SQUARE_EN] ##1 $rose(o_square_wave_out));
  c_per_irq: cover property (per_flag_r && b_r[B_PERIODIC_EN] ##1 !o_irq_oe_n);
  c_alarm: cover property ($rose(alm_flag_r));
  c_set_update: cover property (b_r[B_SET] && xfer);
endmodule // rtsu_top

// *** rtl/rtsu_pkg.sv ***
// constants and types for the rtc rate-select and update-timing block
package rtsu_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TB_HZ = 32_768;
  localparam int unsigned XFER_DELAY_US = 244;
  localparam int unsigned XFER_CYC = int'((longint'(XFER_DELAY_US) * CLK_HZ + 999_999) / 1_000_000);
  localparam int unsigned UPD_CYCLE_US = 1000;
  localparam int unsigned UPD_CYCLE_CYC = int'((longint'(UPD_CYCLE_US) * CLK_HZ + 999_999) / 1_000_000);
  localparam int CHAIN_W = 15;
  // ------------------------------------------------------------
  // register map (byte addresses) and fields
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_TIME = 8'h00;
  localparam logic [7:0] ADR_ALARM = 8'h04;
  localparam logic [7:0] ADR_CTRLA = 8'h08;
  localparam logic [7:0] ADR_CTRLB = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam int A_UPDATING = 7;
  localparam int B_SET = 7;
  localparam int B_PERIODIC_EN = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_SQUARE_EN = 3;
  localparam logic [7:0] B_MASK = 8'hF8;
  localparam logic [7:0] B_RESET = 8'h00;
  localparam int C_SUMMARY = 7;
  localparam int C_PERIODIC = 6;
  localparam int C_ALARM = 5;
  localparam int C_UPD_ENDED = 4;
  localparam logic [2:0] OSC_RESET = 3'h0;
  localparam logic [2:0] OSC_RUN = 3'h2;
  localparam logic [1:0] OSC_HOLD = 2'h3;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_256 = 4'h1;
  localparam logic [3:0] RATE_128 = 4'h2;
  localparam logic [3:0] TAP_256 = 4'h6;
  localparam logic [3:0] TAP_128 = 4'h7;
  localparam logic [3:0] TAP_OFS = 4'h2;
  localparam logic [1:0] DONT_CARE = 2'h3;
  localparam logic [7:0] SEC_MAX = 8'h3B;
  localparam logic [7:0] MIN_MAX = 8'h3B;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rtsu_wb_req_t;
  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtsu_time_t;
  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_PRE = 2'b01,
    UPD_POST = 2'b11,
    UPD_END = 2'b10
  } rtsu_upd_t;
endpackage

// *** dv/rtsu_host.sv ***
// host model: classic wishbone single cycles toward the rtc block
`timescale 1ns/1ps
module rtsu_host (
  input wire logic i_ref_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output rtsu_pkg::rtsu_wb_req_t o_req
);
  import rtsu_pkg::*;
  initial o_req = '0;
  // ------------------------------------------------------------
  // bus cycle
  // ------------------------------------------------------------
  // request held until ack; released lines show inverted values
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    o_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 200);
    q = i_dat;
    o_req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~d};
    if (n >= 200) begin
      tb_top.miscompares++;
      tb_top.tally_and_finish();
    end
    @(posedge i_ref_clk);
  endtask
endmodule // rtsu_host

// *** dv/tb_top.sv ***
// self-checking bench for the rtc rate-select and update-timing block
`timescale 1ns/1ps
module tb_top;
  import rtsu_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  logic o_square_wave_out;
  logic o_irq_out;
  logic o_irq_oe_n;
  rtsu_wb_req_t wb_req;
  int miscompares = 0;
  int checks = 0;
  logic [63:0] exq[$];
  logic [63:0] ent;
  logic [31:0] q;
  logic [23:0] t0;
  logic [7:0] adr;
  logic v;
  int n;
  int k;
  wire logic irq_n = o_irq_oe_n ? 1'b1 : o_irq_out;
  always #50 i_ref_clk = ~i_ref_clk;
  rtsu_top #(.TB_RATE(10_000_000), .UPD_CYC(3000)) i_dut (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_wb_req(wb_req),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat),
    .o_square_wave_out(o_square_wave_out),
    .o_irq_out(o_irq_out),
    .o_irq_oe_n(o_irq_oe_n)
  );
  rtsu_host i_host (
    .i_ref_clk(i_ref_clk),
    .i_ack(o_wb_ack),
    .i_dat(o_wb_dat),
    .o_req(wb_req)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    exq.push_back({mask, exp});
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    i_host.xfer(1'b1, a, d, dummy);
  endtask
  task automatic wait_sq(input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge i_ref_clk);
      cnt++;
    end while (o_square_wave_out !== lvl && cnt < 40000);
    if (cnt >= 40000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // read answers are compared against the oldest note
  always @(posedge i_ref_clk) begin
    if (o_wb_ack === 1'b1 && wb_req.we === 1'b0) begin
      if (exq.size() == 0) check(o_wb_dat, ~o_wb_dat);
      else begin
        ent = exq.pop_front();
        check(o_wb_dat & ent[63:32], ent[31:0] & ent[63:32]);
      end
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hC8E9));
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    check(o_square_wave_out, 1'b0);
    check(irq_n, 1'b1);
    rd(ADR_CTRLA, 32'h0, 32'hFF);
    rd(ADR_CTRLB, 32'h0, 32'hFF);
    rd(ADR_STAT, 32'h0, 32'hFF);
    adr = 8'h14 + 8'(4 * ($urandom % 59));
    wr(adr, $urandom);
    rd(adr, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    wr(ADR_CTRLB, 32'h08);
    for (int r = 1; r < 14; r++) begin
      wr(ADR_CTRLA, {25'h0, OSC_RUN, 4'(r)});
      wait_sq(1'b0, n);
      wait_sq(1'b1, n);
      wait_sq(1'b0, n);
      wait_sq(1'b1, k);
      check(32'(n + k), (r == 1) ? 32'd128 : (r == 2) ? 32'd256 : 32'd1 << (r - 1));
    end
    $display("test rates done");
    for (int o = 0; o < 8; o++) begin
      if (o != 2) begin
        wr(ADR_CTRLA, {25'h0, 3'(o), 4'h3});
        repeat (4) @(posedge i_ref_clk);
        v = o_square_wave_out;
        n = 0;
        repeat (300) begin
          @(posedge i_ref_clk);
          if (o_square_wave_out !== v) n++;
        end
        check(32'(n), 32'h0);
        if (o >= 6) check(v, 1'b0);
      end
    end
    $display("test oscillator field done");
    wr(ADR_CTRLA, {25'h0, OSC_RUN, 4'h3});
    wr(ADR_CTRLB, 32'h40);
    repeat (10) @(posedge i_ref_clk);
    check(o_square_wave_out, 1'b0);
    check(irq_n, 1'b0);
    rd(ADR_STAT, 32'hC0, 32'hC0);
    wr(ADR_CTRLB, 32'h0);
    repeat (3) @(posedge i_ref_clk);
    check(irq_n, 1'b1);
    rd(ADR_STAT, 32'h40, 32'hC0);
    $display("test periodic flag done");
    t0 = {8'($urandom % 24), 8'($urandom % 60), 8'($urandom % 58)};
    wr(ADR_CTRLA, 32'h60);
    wr(ADR_CTRLB, 32'hA0);
    wr(ADR_TIME, {8'h0, t0});
    wr(ADR_ALARM, 32'hC0C0C0);
    wr(ADR_CTRLA, 32'h20);
    rd(ADR_STAT, 32'h0, 32'h0);
    repeat (37000) @(posedge i_ref_clk);
    rd(ADR_TIME, {8'h0, t0}, 32'hFFFFFF);
    check(irq_n, 1'b0);
    rd(ADR_STAT, 32'hB0, 32'hFF);
    rd(ADR_STAT, 32'h0, 32'hFF);
    check(irq_n, 1'b1);
    wr(ADR_CTRLB, 32'h0);
    wr(ADR_ALARM, {8'h0, t0 + 24'h2});
    n = 0;
    do begin
      rd(ADR_CTRLA, 32'h0, 32'h0);
      n++;
    end while (q[7] !== 1'b1 && n < 12000);
    if (n >= 12000) begin
      miscompares++;
      tally_and_finish();
    end
    rd(ADR_TIME, {8'h0, t0}, 32'hFFFFFF);
    repeat (2600) @(posedge i_ref_clk);
    rd(ADR_TIME, {8'h0, t0 + 24'h2}, 32'hFFFFFF);
    rd(ADR_STAT, 32'h20, 32'hFF);
    $display("test update cycle done");
    tally_and_finish();
  end
endmodule // tb_top
